//--- ifm_bus_master.sv
// two-wire bus master model that drives the target from the far side
`timescale 1ns/1ps
module ifm_bus_master #(
   parameter HALF = 8
) (
   // clock
   input  wire core_clk,
   // bus
   input  wire sda,
   output reg  scl,
   output reg  sda_m
);
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   task automatic hold(input integer n);
      repeat (n) @(negedge core_clk);
   endtask
   // data moves two cycles after the clock falls, never beside an edge
   task automatic bit_io(input logic b, output logic r);
      hold(2);
      sda_m = b;
      hold(HALF - 2);
      scl = 1'b1;
      hold(HALF);
      r = sda;
      scl = 1'b0;
   endtask
   task automatic start;
      hold(2);
      sda_m = 1'b1;
      hold(HALF);
      scl = 1'b1;
      hold(HALF);
      sda_m = 1'b0;
      hold(HALF);
      scl = 1'b0;
   endtask
   task automatic stop;
      hold(2);
      sda_m = 1'b0;
      hold(HALF);
      scl = 1'b1;
      hold(HALF);
      sda_m = 1'b1;
      hold(HALF);
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // the last wanted byte is not acknowledged
   task automatic recv(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 0; i < 8; i++) begin
         bit_io(1'b1, r);
         d = {d[6:0], r};
      end
      bit_io(last, r);
   endtask
endmodule

//--- ifm_consts.vh
// constants for the two-wire ferroelectric memory target
`ifndef IFM_CONSTS_VH
`define IFM_CONSTS_VH

// ----------------------------------------------------------------
// controller states
// ----------------------------------------------------------------
`define IFM_ST_IDLE      3'h0
`define IFM_ST_RX        3'h1
`define IFM_ST_RACK      3'h2
`define IFM_ST_TX        3'h3
`define IFM_ST_TACK      3'h4

// ----------------------------------------------------------------
// byte position within a frame
// ----------------------------------------------------------------
`define IFM_PH_SLAVE     2'h0
`define IFM_PH_ADDR_HI   2'h1
`define IFM_PH_ADDR_LO   2'h2
`define IFM_PH_DATA      2'h3

// ----------------------------------------------------------------
// target address byte fields
// ----------------------------------------------------------------
`define IFM_TYPE_MSB     7
`define IFM_TYPE_LSB     4
`define IFM_DSEL_MSB     3
`define IFM_DSEL_LSB     2
`define IFM_BANK_BIT     1
`define IFM_RW_BIT       0

// ----------------------------------------------------------------
// type codes (values are arbitrary)
// ----------------------------------------------------------------
`define IFM_MEM_TYPE     4'h5
`define IFM_ID_TYPE      4'hC
`define IFM_SLEEP_TYPE   4'h8

// ----------------------------------------------------------------
// identity contents and reset values (values are arbitrary)
// ----------------------------------------------------------------
`define IFM_ID_VALUE     24'h123456
`define IFM_SERIAL_VALUE 64'h0011223344556677
`define IFM_ID_BYTES     4'h3
`define IFM_SN_BYTES     4'h8
`define IFM_ADDR_RST     17'h00000

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define IFM_CLK_PERIOD_NS 100

`endif

//--- ifm_target.v
// two-wire target controller with a byte-wide ferroelectric memory array
`timescale 1ns/1ps
`include "ifm_consts.vh"
// How it works
// - answer only when the address select bits equal the device select pins
// - unconnected device select pins read as low through pad pulls
// - sample bits on clock rise, change outgoing data on clock fall
// - write protect high blocks every array write
// - write protect low allows all writes; open pin reads low
// - data line is open drain: pull low or release only
// - each data byte is stored on the clock fall after its eighth bit
// - a new frame is accepted straight after a write, no busy time
// - array of 131072 locations of 8 bits
// - read-only identification bytes, unaffected by writes
// - serial number variant adds read-only serial number bytes
// - works at 100 kHz and 400 kHz bus rates; 3.4 MHz needs a core clock well above it
// - sleep is entered once the sleep request is taken, stop or not
// - first byte: bits 3-2 select, bit 1 upper bank, bit 0 read
// - 17-bit address advances after each data byte, wraps to zero
// - read continues only while the master acknowledges
// - stop aborts any operation and returns to idle
module ifm_target #(
   parameter ADDR_W     = 17,
   parameter HAS_SERIAL = 1,
   parameter [3:0]  MEM_TYPE   = `IFM_MEM_TYPE,
   parameter [3:0]  ID_TYPE    = `IFM_ID_TYPE,
   parameter [3:0]  SLEEP_TYPE = `IFM_SLEEP_TYPE,
   parameter [23:0] ID_VALUE   = `IFM_ID_VALUE,
   parameter [63:0] SERIAL_NUM = `IFM_SERIAL_VALUE
) (
   // clock and reset
   input  wire       core_clk,
   input  wire       nrst,
   // two-wire bus pins
   input  wire       scl,
   input  wire       sda_in,
   output reg        sda_out,
   output reg        sda_oe,
   // strap pins
   input  wire [1:0] device_select_pins,
   input  wire       write_protect,
   // status
   output reg        sleep_mode
);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   reg  [7:0]        mem [0:(1<<ADDR_W)-1];

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   reg  [4:0]        sync1;
   reg  [4:0]        sync2;
   reg               scl_d;
   reg               sda_d;
   wire              scl_s  = sync2[0];
   wire              sda_s  = sync2[1];
   wire [1:0]        dsel_s = sync2[3:2];
   wire              wp_s   = sync2[4];

   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sync1 <= 5'h03;
         sync2 <= 5'h03;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         sync1 <= {write_protect, device_select_pins, sda_in, scl};
         sync2 <= sync1;
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
   wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

   // ----------------------------------------------------------------
   // identification byte selector
   // ----------------------------------------------------------------
   function [7:0] id_byte;
      input [3:0] idx;
      begin
         case (idx)
            4'h0:    id_byte = ID_VALUE[23:16];
            4'h1:    id_byte = ID_VALUE[15:8];
            4'h2:    id_byte = ID_VALUE[7:0];
            default: id_byte = SERIAL_NUM[8'd63 - {idx - 4'h3, 3'h0} -: 8];
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // controller
   // ----------------------------------------------------------------
   reg  [2:0]        state;
   reg  [1:0]        phase;
   reg  [2:0]        bit_cnt;
   reg               byte_done;
   reg  [7:0]        shreg;
   reg               rd_mode;
   reg               id_mode;
   reg               ack_ok;
   reg               do_sleep;
   reg  [3:0]        id_idx;
   reg  [ADDR_W-1:0] addr;

   wire [7:0]        rx_byte   = shreg;
   wire [3:0]        id_limit  = HAS_SERIAL ? (`IFM_ID_BYTES + `IFM_SN_BYTES) : `IFM_ID_BYTES;
   wire [3:0]        next_id   = (id_idx + 4'h1 >= id_limit) ? 4'h0 : id_idx + 4'h1;
   wire              sel_match = (rx_byte[`IFM_DSEL_MSB:`IFM_DSEL_LSB] == dsel_s);
   wire [3:0]        rx_type   = rx_byte[`IFM_TYPE_MSB:`IFM_TYPE_LSB];
   wire [7:0]        id_cur    = id_byte(id_idx);
   // the store strobe mirrors the data-byte branch of the controller below
   wire              mem_we    = (state == `IFM_ST_RX) && scl_fall && byte_done &&
                                 (phase == `IFM_PH_DATA) && !wp_s && !stop_c && !start_c;

   // the array has no reset, so it is written outside the reset process
   always @(posedge core_clk) begin
      if (mem_we)
         mem[addr] <= rx_byte;
   end

   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state      <= `IFM_ST_IDLE;
         phase      <= `IFM_PH_SLAVE;
         bit_cnt    <= 3'h0;
         byte_done  <= 1'b0;
         shreg      <= 8'h00;
         rd_mode    <= 1'b0;
         id_mode    <= 1'b0;
         ack_ok     <= 1'b0;
         do_sleep   <= 1'b0;
         id_idx     <= 4'h0;
         addr       <= `IFM_ADDR_RST;
         sda_out    <= 1'b0;
         sda_oe     <= 1'b0;
         sleep_mode <= 1'b0;
      end else begin
         sda_out <= 1'b0;
         if (stop_c) begin
            state  <= `IFM_ST_IDLE;
            sda_oe <= 1'b0;
         end else if (start_c) begin
            // a start, repeated or not, also restarts any operation
            state      <= `IFM_ST_RX;
            phase      <= `IFM_PH_SLAVE;
            bit_cnt    <= 3'h0;
            byte_done  <= 1'b0;
            sda_oe     <= 1'b0;
            sleep_mode <= 1'b0;
         end else begin
            case (state)
               `IFM_ST_RX: begin
                  if (scl_rise && !byte_done) begin
                     shreg   <= {shreg[6:0], sda_s};
                     bit_cnt <= bit_cnt + 3'h1;
                     if (bit_cnt == 3'h7)
                        byte_done <= 1'b1;
                  end else if (scl_fall && byte_done) begin
                     byte_done <= 1'b0;
                     state     <= `IFM_ST_RACK;
                     sda_oe    <= 1'b1;
                     do_sleep  <= 1'b0;
                     case (phase)
                        `IFM_PH_SLAVE: begin
                           rd_mode <= rx_byte[`IFM_RW_BIT];
                           id_mode <= (rx_type == ID_TYPE);
                           id_idx  <= 4'h0;
                           if (sel_match && rx_type == MEM_TYPE) begin
                              // a read frame carries no address bytes
                              phase <= rx_byte[`IFM_RW_BIT] ? `IFM_PH_DATA : `IFM_PH_ADDR_HI;
                              if (!rx_byte[`IFM_RW_BIT])
                                 addr[ADDR_W-1] <= rx_byte[`IFM_BANK_BIT];
                           end else if (sel_match && rx_type == ID_TYPE && rx_byte[`IFM_RW_BIT]) begin
                              phase <= `IFM_PH_DATA;
                           end else if (sel_match && rx_type == SLEEP_TYPE && !rx_byte[`IFM_RW_BIT]) begin
                              do_sleep <= 1'b1;
                           end else begin
                              // not addressed, or an hs master code: stay off the bus
                              sda_oe <= 1'b0;
                              state  <= `IFM_ST_IDLE;
                           end
                        end
                        `IFM_PH_ADDR_HI: begin
                           addr[15:8] <= rx_byte;
                           phase      <= `IFM_PH_ADDR_LO;
                        end
                        `IFM_PH_ADDR_LO: begin
                           addr[7:0] <= rx_byte;
                           phase     <= `IFM_PH_DATA;
                        end
                        default: begin
                           // the byte itself is stored through mem_we
                           addr <= addr + {{(ADDR_W-1){1'b0}}, 1'b1};
                        end
                     endcase
                  end
               end
               `IFM_ST_RACK: begin
                  if (scl_fall) begin
                     sda_oe  <= 1'b0;
                     bit_cnt <= 3'h0;
                     if (do_sleep) begin
                        // sleep does not wait for the stop
                        sleep_mode <= 1'b1;
                        state      <= `IFM_ST_IDLE;
                     end else if (rd_mode && phase != `IFM_PH_ADDR_HI && phase != `IFM_PH_ADDR_LO) begin
                        state <= `IFM_ST_TX;
                        if (id_mode) begin
                           shreg  <= id_byte(id_idx);
                           sda_oe <= ~id_cur[7];
                           id_idx <= next_id;
                        end else begin
                           shreg  <= mem[addr];
                           sda_oe <= ~mem[addr][7];
                           addr   <= addr + {{(ADDR_W-1){1'b0}}, 1'b1};
                        end
                     end else begin
                        state <= `IFM_ST_RX;
                     end
                  end
               end
               `IFM_ST_TX: begin
                  if (scl_fall) begin
                     if (bit_cnt == 3'h7) begin
                        sda_oe <= 1'b0;
                        state  <= `IFM_ST_TACK;
                     end else begin
                        bit_cnt <= bit_cnt + 3'h1;
                        shreg   <= {shreg[6:0], 1'b0};
                        sda_oe  <= ~shreg[6];
                     end
                  end
               end
               `IFM_ST_TACK: begin
                  if (scl_rise) begin
                     ack_ok <= ~sda_s;
                  end else if (scl_fall) begin
                     bit_cnt <= 3'h0;
                     if (ack_ok) begin
                        state <= `IFM_ST_TX;
                        if (id_mode) begin
                           shreg  <= id_byte(id_idx);
                           sda_oe <= ~id_cur[7];
                           id_idx <= next_id;
                        end else begin
                           shreg  <= mem[addr];
                           sda_oe <= ~mem[addr][7];
                           addr   <= addr + {{(ADDR_W-1){1'b0}}, 1'b1};
                        end
                     end else begin
                        state <= `IFM_ST_IDLE;
                     end
                  end
               end
               default: begin
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end

   // the bus is sampled at core_clk: the 3.4 MHz rate needs a core clock
   // well above it, at 10 MHz only 100 and 400 kHz have margin

endmodule

//--- ifm_target_assertions.sv
// concurrent checks on the pins of the two-wire memory target
`timescale 1ns/1ps
module ifm_target_assertions (
   // clock and reset
   input logic       core_clk,
   input logic       nrst,
   // bus pins
   input logic       scl,
   input logic       sda_in,
   input logic       sda_out,
   input logic       sda_oe,
   // straps and status
   input logic [1:0] device_select_pins,
   input logic       write_protect,
   input logic       sleep_mode
);
   a_drain_only_low: assert property (@(posedge core_clk) disable iff (!nrst) sda_out == 1'b0)
      else $error("data pin output value not low");
   a_quiet_after_reset: assert property (@(posedge core_clk) disable iff (!nrst) $rose(nrst) |-> !sda_oe [*3])
      else $error("data pin pulled right after reset");
   a_hold_scl_high: assert property (@(posedge core_clk) disable iff (!nrst) scl && $past(scl) |-> $stable(sda_oe))
      else $error("data pin changed while bus clock high");
   a_drive_after_fall: assert property (@(posedge core_clk) disable iff (!nrst) $rose(sda_oe) |-> $past(!scl, 2))
      else $error("data pin pulled without a bus clock fall");
   a_release_scl_low: assert property (@(posedge core_clk) disable iff (!nrst) $fell(sda_oe) |-> !scl)
      else $error("data pin released while bus clock high");
   a_sleep_scl_low: assert property (@(posedge core_clk) disable iff (!nrst) $rose(sleep_mode) |-> !scl)
      else $error("sleep entered outside the clock low phase");
   a_wake_on_start: assert property (@(posedge core_clk) disable iff (!nrst) $fell(sleep_mode) |-> scl && !sda_in)
      else $error("sleep left without a start");
   a_silent_asleep: assert property (@(posedge core_clk) disable iff (!nrst) sleep_mode |-> !sda_oe)
      else $error("data pin pulled while asleep");
endmodule

bind ifm_target ifm_target_assertions ifm_target_assertions_i (.core_clk(core_clk), .nrst(nrst), .scl(scl),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .device_select_pins(device_select_pins),
   .write_protect(write_protect), .sleep_mode(sleep_mode));

//--- ifm_target_test.sv
// self-checking bench for the two-wire memory target
`timescale 1ns/1ps
`include "ifm_consts.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module ifm_target_test;
   logic         core_clk = 1'b0;
   logic         nrst = 1'b0;
   logic [1:0]   device_select_pins = 2'h0;
   logic         write_protect = 1'b0;
   wire          scl, sda_m, sda_out, sda_oe, sleep_mode;
   wire          sda = sda_m & (sda_oe ? sda_out : 1'b1);
   integer       mismatches = 0, checks = 0, seed = 24991;
   logic [7:0]   mem [int];
   logic [7:0]   d;
   logic         ack;
   logic [87:0]  id = {`IFM_ID_VALUE, `IFM_SERIAL_VALUE};
   always #50 core_clk = ~core_clk;
   ifm_target ifm_target_i (.core_clk(core_clk), .nrst(nrst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .device_select_pins(device_select_pins), .write_protect(write_protect), .sleep_mode(sleep_mode));
   ifm_bus_master ifm_bus_master_i (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_m(sda_m));
   task automatic sel(input logic [3:0] ty, input logic [1:0] s, input logic bank, input logic rd, input logic exp);
      ifm_bus_master_i.start;
      ifm_bus_master_i.send({ty, s, bank, rd}, ack);
      `CHK(ack, exp)
   endtask
   task automatic set_addr(input logic [16:0] a);
      sel(`IFM_MEM_TYPE, device_select_pins, a[16], 1'b0, 1'b1);
      ifm_bus_master_i.send(a[15:8], ack);
      `CHK(ack, 1'b1)
      ifm_bus_master_i.send(a[7:0], ack);
      `CHK(ack, 1'b1)
   endtask
   task automatic wr(input logic [16:0] a, input integer n);
      set_addr(a);
      for (int k = 0; k < n; k++) begin
         d = 8'($random(seed));
         ifm_bus_master_i.send(d, ack);
         `CHK(ack, 1'b1)
         if (!write_protect) mem[a] = d;
         a = a + 17'h00001;
      end
      ifm_bus_master_i.stop;
   endtask
   task automatic rd(input logic [16:0] a, input integer n);
      set_addr(a);
      sel(`IFM_MEM_TYPE, device_select_pins, 1'b0, 1'b1, 1'b1);
      for (int k = 0; k < n; k++) begin
         ifm_bus_master_i.recv(k == n - 1, d);
         `CHK(d, mem[a])
         a = a + 17'h00001;
      end
      ifm_bus_master_i.stop;
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge core_clk);
      mismatches++;
      results;
   end
   initial begin
      repeat (6) @(posedge core_clk);
      @(negedge core_clk) nrst = 1'b1;
      ifm_bus_master_i.hold(4);
      // strap pins start driven low, so select 0 answers first
      for (int p = 0; p < 4; p++) begin
         for (int s = 0; s < 4; s++) begin
            sel(`IFM_MEM_TYPE, s[1:0], 1'b0, 1'b0, s == p);
            ifm_bus_master_i.stop;
         end
         @(negedge core_clk) device_select_pins = 2'(p + 1);
      end
      @(negedge core_clk) device_select_pins = 2'($random(seed));
      $display("select test done");
      // crossing the top of the array checks bank bit and wrap
      wr(17'h1FFFE, 4);
      rd(17'h1FFFE, 4);
      wr(17'h0A5C3, 3);
      rd(17'h0A5C3, 3);
      $display("write read test done");
      @(negedge core_clk) write_protect = 1'b1;
      wr(17'h1FFFE, 4);
      @(negedge core_clk) write_protect = 1'b0;
      rd(17'h1FFFE, 4);
      $display("protect test done");
      sel(`IFM_ID_TYPE, device_select_pins, 1'b0, 1'b1, 1'b1);
      for (int k = 0; k < 11; k++) begin
         ifm_bus_master_i.recv(k == 10, d);
         `CHK(d, id[87 - 8 * k -: 8])
      end
      ifm_bus_master_i.stop;
      $display("identity test done");
      sel(`IFM_SLEEP_TYPE, device_select_pins, 1'b0, 1'b0, 1'b1);
      ifm_bus_master_i.hold(6);
      `CHK(sleep_mode, 1'b1)
      rd(17'h0A5C3, 2);
      `CHK(sleep_mode, 1'b0)
      $display("sleep test done");
      results;
   end
endmodule
